// ===== dpsp_pkg.sv
// shared widths, field positions and mode codes for the dual-ported synchronous ram
// assumes both ports run on the one clock and a synchronous active-high reset
package dpsp_pkg;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int ADDR_W = 13;
	localparam int WORDS_FULL = 8192;
	localparam int WORDS_HALF = 4096;
	// lane positions inside a word
	localparam int LOWER_LSB = 0;
	localparam int UPPER_LSB = 9;
	localparam int LANE_LOWER = 0;
	localparam int LANE_UPPER = 1;
	// output stage mode pin codes
	localparam logic MODE_FLOW = 1'h0;
	localparam logic MODE_PIPE = 1'h1;
	// counter clear target and step
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;
	localparam logic [DATA_W-1:0] WORD_ZERO = 18'h0_0000;
	localparam logic [LANES-1:0] LANES_OFF = 2'h3;
	typedef logic [ADDR_W-1:0] dpsp_addr_t;
	typedef logic [DATA_W-1:0] dpsp_word_t;
	typedef logic [LANES-1:0] dpsp_lanes_t;
endpackage

// ===== dpsp_port_parts.sv
// per-port pieces: the address counter and the select / output stage
// assumes controls come from logic on the same clock, so no synchronisers
`timescale 1ns/1ps
module dpsp_addr_counter
	import dpsp_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire dpsp_pkg::dpsp_addr_t address_in,
	input wire logic address_load_strobe_n,
	input wire logic counter_advance_enable_n,
	input wire logic counter_clear_n,
	output dpsp_pkg::dpsp_addr_t addr_nxt,
	output dpsp_pkg::dpsp_addr_t addr_r
);
	// clear beats load, load beats advance, otherwise hold; selects play no part
	always_comb begin
		if (!counter_clear_n) begin
			addr_nxt = ADDR_ZERO;
		end else if (!address_load_strobe_n) begin
			addr_nxt = address_in;
		end else if (!counter_advance_enable_n) begin
			addr_nxt = addr_r + ADDR_STEP;
		end else begin
			addr_nxt = addr_r;
		end
	end

	// wraps silently at the top of the address space
	always_ff @(posedge clock) begin
		if (reset) begin
			addr_r <= ADDR_ZERO;
		end else begin
			addr_r <= addr_nxt;
		end
	end
endmodule

module dpsp_port_stage
	import dpsp_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic chip_select_low_active,
	input wire logic chip_select_high_active,
	input wire logic upper_byte_select_n,
	input wire logic lower_byte_select_n,
	input wire logic read_write,
	input wire logic output_enable_n,
	input wire logic output_stage_mode,
	input wire dpsp_pkg::dpsp_word_t read_word,
	output dpsp_pkg::dpsp_word_t data_out,
	output dpsp_pkg::dpsp_lanes_t data_oe_n
);
	logic sel_now;
	logic sel_r1;
	logic sel_r2;
	logic rd_r1;
	logic rd_r2;
	dpsp_lanes_t byte_r;
	dpsp_word_t flow_r;
	dpsp_word_t data_out_r;
	logic active;
	logic reading;

	assign sel_now = !chip_select_low_active && chip_select_high_active;

	// selects take one stage, a second for pipelined timing
	always_ff @(posedge clock) begin
		if (reset) begin
			sel_r1 <= 1'h0;
			sel_r2 <= 1'h0;
			rd_r1 <= 1'h0;
			rd_r2 <= 1'h0;
		end else begin
			sel_r1 <= sel_now;
			sel_r2 <= sel_r1;
			rd_r1 <= read_write;
			rd_r2 <= rd_r1;
		end
	end

	// byte selects are always single staged, whatever the mode
	always_ff @(posedge clock) begin
		if (reset) begin
			byte_r <= {LANES{1'h0}};
		end else begin
			byte_r[LANE_UPPER] <= !upper_byte_select_n;
			byte_r[LANE_LOWER] <= !lower_byte_select_n;
		end
	end

	// flow-through shows the word at the edge, pipelined one edge later
	always_ff @(posedge clock) begin
		if (reset) begin
			flow_r <= WORD_ZERO;
			data_out_r <= WORD_ZERO;
		end else begin
			flow_r <= read_word;
			data_out_r <= (output_stage_mode == MODE_PIPE) ? flow_r : read_word;
		end
	end

	assign active = (output_stage_mode == MODE_PIPE) ? sel_r2 : sel_r1;
	assign reading = (output_stage_mode == MODE_PIPE) ? rd_r2 : rd_r1;
	assign data_out = data_out_r;

	// output enable is not clocked: it cuts the drive at once
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			data_oe_n[i] = !(active && reading && byte_r[i] && !output_enable_n);
		end
	end
endmodule

// ===== dpsp_ram.sv
// two-port synchronous static ram: word array and two independent ports a and b
// assumes both hosts run on this clock and hold inputs steady around each edge
`timescale 1ns/1ps
module dpsp_ram
	import dpsp_pkg::*;
#(
	parameter int WORDS = dpsp_pkg::WORDS_FULL
)
(
	input wire logic clock,
	input wire logic reset,
	// port a
	input wire logic port_a_chip_select_low_active,
	input wire logic port_a_chip_select_high_active,
	input wire logic port_a_upper_byte_select_n,
	input wire logic port_a_lower_byte_select_n,
	input wire logic port_a_read_write,
	input wire logic port_a_output_enable_n,
	input wire logic port_a_output_stage_mode,
	input wire logic port_a_address_load_strobe_n,
	input wire logic port_a_counter_advance_enable_n,
	input wire logic port_a_counter_clear_n,
	input wire dpsp_pkg::dpsp_addr_t port_a_address,
	input wire dpsp_pkg::dpsp_word_t port_a_data_in,
	output dpsp_pkg::dpsp_word_t port_a_data_out,
	output dpsp_pkg::dpsp_lanes_t port_a_data_oe_n,
	// port b
	input wire logic port_b_chip_select_low_active,
	input wire logic port_b_chip_select_high_active,
	input wire logic port_b_upper_byte_select_n,
	input wire logic port_b_lower_byte_select_n,
	input wire logic port_b_read_write,
	input wire logic port_b_output_enable_n,
	input wire logic port_b_output_stage_mode,
	input wire logic port_b_address_load_strobe_n,
	input wire logic port_b_counter_advance_enable_n,
	input wire logic port_b_counter_clear_n,
	input wire dpsp_pkg::dpsp_addr_t port_b_address,
	input wire dpsp_pkg::dpsp_word_t port_b_data_in,
	output dpsp_pkg::dpsp_word_t port_b_data_out,
	output dpsp_pkg::dpsp_lanes_t port_b_data_oe_n
);
	// only as many index bits as the array has words; the 4K build drops the top bit
	localparam int IDX_W = $clog2(WORDS);

	dpsp_word_t mem [WORDS];
	dpsp_addr_t a_addr_nxt;
	dpsp_addr_t a_addr_r;
	dpsp_addr_t b_addr_nxt;
	dpsp_addr_t b_addr_r;
	logic [IDX_W-1:0] a_idx;
	logic [IDX_W-1:0] b_idx;
	dpsp_word_t a_rdata;
	dpsp_word_t b_rdata;
	logic a_sel;
	logic b_sel;
	logic a_wr_up;
	logic a_wr_lo;
	logic b_wr_up;
	logic b_wr_lo;

	// one counter per port, no shared state between them
	dpsp_addr_counter u_a_counter (
		.clock(clock),
		.reset(reset),
		.address_in(port_a_address),
		.address_load_strobe_n(port_a_address_load_strobe_n),
		.counter_advance_enable_n(port_a_counter_advance_enable_n),
		.counter_clear_n(port_a_counter_clear_n),
		.addr_nxt(a_addr_nxt),
		.addr_r(a_addr_r)
	);

	dpsp_addr_counter u_b_counter (
		.clock(clock),
		.reset(reset),
		.address_in(port_b_address),
		.address_load_strobe_n(port_b_address_load_strobe_n),
		.counter_advance_enable_n(port_b_counter_advance_enable_n),
		.counter_clear_n(port_b_counter_clear_n),
		.addr_nxt(b_addr_nxt),
		.addr_r(b_addr_r)
	);

	// the address used at an edge is the counter's next value
	assign a_idx = a_addr_nxt[IDX_W-1:0];
	assign b_idx = b_addr_nxt[IDX_W-1:0];
	assign a_rdata = mem[a_idx];
	assign b_rdata = mem[b_idx];

	// write lanes are decided from the inputs at the edge
	assign a_sel = !port_a_chip_select_low_active && port_a_chip_select_high_active;
	assign b_sel = !port_b_chip_select_low_active && port_b_chip_select_high_active;
	assign a_wr_up = a_sel && !port_a_read_write && !port_a_upper_byte_select_n;
	assign a_wr_lo = a_sel && !port_a_read_write && !port_a_lower_byte_select_n;
	assign b_wr_up = b_sel && !port_b_read_write && !port_b_upper_byte_select_n;
	assign b_wr_lo = b_sel && !port_b_read_write && !port_b_lower_byte_select_n;

	// same word written by both ports in one edge: port a is applied last and wins
	always_ff @(posedge clock) begin
		if (b_wr_up) begin
			mem[b_idx][UPPER_LSB +: LANE_W] <= port_b_data_in[UPPER_LSB +: LANE_W];
		end
		if (b_wr_lo) begin
			mem[b_idx][LOWER_LSB +: LANE_W] <= port_b_data_in[LOWER_LSB +: LANE_W];
		end
		if (a_wr_up) begin
			mem[a_idx][UPPER_LSB +: LANE_W] <= port_a_data_in[UPPER_LSB +: LANE_W];
		end
		if (a_wr_lo) begin
			mem[a_idx][LOWER_LSB +: LANE_W] <= port_a_data_in[LOWER_LSB +: LANE_W];
		end
	end

	// a read in the same edge as a write to that word returns the old contents
	dpsp_port_stage u_a_stage (
		.clock(clock),
		.reset(reset),
		.chip_select_low_active(port_a_chip_select_low_active),
		.chip_select_high_active(port_a_chip_select_high_active),
		.upper_byte_select_n(port_a_upper_byte_select_n),
		.lower_byte_select_n(port_a_lower_byte_select_n),
		.read_write(port_a_read_write),
		.output_enable_n(port_a_output_enable_n),
		.output_stage_mode(port_a_output_stage_mode),
		.read_word(a_rdata),
		.data_out(port_a_data_out),
		.data_oe_n(port_a_data_oe_n)
	);

	dpsp_port_stage u_b_stage (
		.clock(clock),
		.reset(reset),
		.chip_select_low_active(port_b_chip_select_low_active),
		.chip_select_high_active(port_b_chip_select_high_active),
		.upper_byte_select_n(port_b_upper_byte_select_n),
		.lower_byte_select_n(port_b_lower_byte_select_n),
		.read_write(port_b_read_write),
		.output_enable_n(port_b_output_enable_n),
		.output_stage_mode(port_b_output_stage_mode),
		.read_word(b_rdata),
		.data_out(port_b_data_out),
		.data_oe_n(port_b_data_oe_n)
	);

	// checks below watch port a in full and port b for its core behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// helper: port a mode held over the last two edges for flow, three for pipelined
	logic a_mode_d1;
	logic a_mode_d2;
	always_ff @(posedge clock) begin
		if (reset) begin
			a_mode_d1 <= MODE_FLOW;
			a_mode_d2 <= MODE_FLOW;
		end else begin
			a_mode_d1 <= port_a_output_stage_mode;
			a_mode_d2 <= a_mode_d1;
		end
	end
	logic a_flow_steady;
	logic a_pipe_steady;
	assign a_flow_steady = (port_a_output_stage_mode == MODE_FLOW) && (a_mode_d1 == MODE_FLOW);
	assign a_pipe_steady = (port_a_output_stage_mode == MODE_PIPE) && (a_mode_d1 == MODE_PIPE)
		&& (a_mode_d2 == MODE_PIPE);

	a_deselect_flow_float: assert property (
		(!a_sel && port_a_output_stage_mode == MODE_FLOW) ##1 a_flow_steady |-> port_a_data_oe_n == LANES_OFF)
		else $error("flow mode lanes driven after deselect");

	a_deselect_pipe_two: assert property (
		(!a_sel && port_a_output_stage_mode == MODE_PIPE) ##2 a_pipe_steady |-> port_a_data_oe_n == LANES_OFF)
		else $error("pipelined deselect not effective two cycles later");

	a_pipe_select_lag: assert property (
		(a_sel && port_a_read_write && !port_a_lower_byte_select_n) ##1
		(!a_sel && !port_a_lower_byte_select_n && !port_a_output_enable_n) ##1
		(a_pipe_steady && !port_a_output_enable_n)
		|-> !port_a_data_oe_n[LANE_LOWER])
		else $error("pipelined select dropped one cycle early");

	a_write_upper_lane: assert property (
		a_wr_up |=> mem[$past(a_idx)][UPPER_LSB +: LANE_W] == $past(port_a_data_in[UPPER_LSB +: LANE_W]))
		else $error("upper lane write lost");

	a_write_lower_kept: assert property (
		(a_sel && !port_a_read_write && port_a_lower_byte_select_n && !b_wr_lo)
		|=> mem[$past(a_idx)][LOWER_LSB +: LANE_W] == $past(a_rdata[LOWER_LSB +: LANE_W]))
		else $error("deselected lower lane was written");

	a_read_lane_drive: assert property (
		(a_sel && port_a_read_write && !port_a_upper_byte_select_n && port_a_lower_byte_select_n)
		##1 (a_flow_steady && !port_a_output_enable_n)
		|-> port_a_data_oe_n == 2'h1)
		else $error("read lane enables do not follow byte selects");

	a_oe_async_float: assert property (
		port_a_output_enable_n |-> port_a_data_oe_n == LANES_OFF)
		else $error("lanes driven while output enable high");

	a_byte_single_stage: assert property (
		port_a_upper_byte_select_n |=> port_a_data_oe_n[LANE_UPPER])
		else $error("upper byte select not single staged");

	a_counter_load: assert property (
		(port_a_counter_clear_n && !port_a_address_load_strobe_n) |=> a_addr_r == $past(port_a_address))
		else $error("external address not loaded");

	a_counter_advance: assert property (
		(port_a_counter_clear_n && port_a_address_load_strobe_n && !port_a_counter_advance_enable_n)
		|=> a_addr_r == $past(a_addr_r) + ADDR_STEP)
		else $error("counter did not advance by one");

	a_counter_hold: assert property (
		(port_a_counter_clear_n && port_a_address_load_strobe_n && port_a_counter_advance_enable_n)
		|=> $stable(a_addr_r))
		else $error("counter moved while held");

	a_counter_clear: assert property (
		!port_a_counter_clear_n |=> a_addr_r == ADDR_ZERO)
		else $error("counter clear did not reach zero");

	// flow check on selected reads only, pipelined check on every cycle: the array is never reset, so idle fetches may be unknown
	a_flow_data_time: assert property (
		(a_flow_steady && a_sel && port_a_read_write) |=> port_a_data_out == $past(a_rdata))
		else $error("flow-through data not shown at the edge");

	a_pipe_data_time: assert property (
		a_pipe_steady ##1 (port_a_output_stage_mode == MODE_PIPE) |-> port_a_data_out == $past(a_rdata, 2))
		else $error("pipelined data not one cycle behind");

	a_port_b_alone: assert property (
		(!port_b_counter_clear_n && !port_a_address_load_strobe_n && port_a_counter_clear_n)
		|=> b_addr_r == ADDR_ZERO && a_addr_r == $past(port_a_address))
		else $error("ports interfere in counter control");

	// port b: the same core checks, for flow timing only
	a_b_deselect_float: assert property (
		(!b_sel && port_b_output_stage_mode == MODE_FLOW) ##1 (port_b_output_stage_mode == MODE_FLOW)
		|-> port_b_data_oe_n == LANES_OFF)
		else $error("port b lanes driven after deselect");

	a_b_write_lower: assert property (
		(b_wr_lo && !a_wr_lo)
		|=> mem[$past(b_idx)][LOWER_LSB +: LANE_W] == $past(port_b_data_in[LOWER_LSB +: LANE_W]))
		else $error("port b lower lane write lost");

	a_b_read_lanes: assert property (
		(b_sel && port_b_read_write && port_b_upper_byte_select_n && !port_b_lower_byte_select_n
		&& port_b_output_stage_mode == MODE_FLOW)
		##1 (port_b_output_stage_mode == MODE_FLOW && !port_b_output_enable_n)
		|-> port_b_data_oe_n == 2'h2)
		else $error("port b read lane enables do not follow byte selects");

	a_b_oe_float: assert property (
		port_b_output_enable_n |-> port_b_data_oe_n == LANES_OFF)
		else $error("port b lanes driven while output enable high");

	a_b_byte_stage: assert property (
		port_b_lower_byte_select_n |=> port_b_data_oe_n[LANE_LOWER])
		else $error("port b lower byte select not single staged");

	a_b_counter_load: assert property (
		(port_b_counter_clear_n && !port_b_address_load_strobe_n) |=> b_addr_r == $past(port_b_address))
		else $error("port b external address not loaded");

	a_b_counter_advance: assert property (
		(port_b_counter_clear_n && port_b_address_load_strobe_n && !port_b_counter_advance_enable_n)
		|=> b_addr_r == $past(b_addr_r) + ADDR_STEP)
		else $error("port b counter did not advance by one");

	a_b_counter_hold: assert property (
		(port_b_counter_clear_n && port_b_address_load_strobe_n && port_b_counter_advance_enable_n)
		|=> $stable(b_addr_r))
		else $error("port b counter moved while held");

	a_b_counter_clear: assert property (
		!port_b_counter_clear_n |=> b_addr_r == ADDR_ZERO)
		else $error("port b counter clear did not reach zero");

	a_b_flow_data: assert property (
		(b_sel && port_b_read_write && port_b_output_stage_mode == MODE_FLOW)
		|=> port_b_data_out == $past(b_rdata))
		else $error("port b flow-through data not shown at the edge");

	// main scenarios
	c_flow_read: cover property (
		(a_sel && port_a_read_write) ##1 (a_flow_steady && port_a_data_oe_n == 2'h0));
	c_pipe_read: cover property (
		(a_sel && port_a_read_write) ##2 (a_pipe_steady && port_a_data_oe_n == 2'h0));
	c_write_both: cover property (a_wr_up && a_wr_lo && b_wr_up && b_wr_lo);
	c_both_read: cover property ((a_sel && port_a_read_write) && (b_sel && port_b_read_write));
	c_burst_advance: cover property (
		!port_a_address_load_strobe_n ##1 !port_a_counter_advance_enable_n [*3]);
endmodule

// ===== dpsp_host.sv
// host model: drives every input of one ram port, one access per clock
// assumes the ram samples its inputs at the rising edge of the shared clock
`timescale 1ns/1ps
module dpsp_host
	import dpsp_pkg::*;
(
	input wire logic clock,
	output logic cs_low,
	output logic cs_high,
	output logic ub_n,
	output logic lb_n,
	output logic rw,
	output logic oe_n,
	output logic mode,
	output logic ads_n,
	output logic cnt_n,
	output logic clr_n,
	output dpsp_pkg::dpsp_addr_t addr,
	output dpsp_pkg::dpsp_word_t din
);
	import dpsp_pkg::*;

	// idle port at time zero: deselected, counter held
	initial begin
		{cs_low, cs_high, ub_n, lb_n, rw, oe_n} = 6'h3e;
		mode = MODE_FLOW;
		{ads_n, cnt_n, clr_n} = 3'h7;
		addr = ADDR_ZERO;
		din = WORD_ZERO;
	end

	// changes land at the falling edge so they sit still around the rising one
	task automatic drive(input logic sel, input logic rd, input logic [1:0] bs_n, input logic [2:0] ctl_n,
		input dpsp_addr_t a, input dpsp_word_t d);
		@(negedge clock);
		cs_low = !sel;
		cs_high = sel;
		{ub_n, lb_n} = bs_n;
		rw = rd;
		{ads_n, cnt_n, clr_n} = ctl_n;
		// unused address and data are scrambled so a stale value cannot pass
		addr = !ctl_n[2] ? a : ~addr;
		din = (sel && !rd) ? d : ~din;
	endtask

	task automatic idle();
		drive(1'b0, 1'b1, 2'h3, 3'h7, ADDR_ZERO, WORD_ZERO);
	endtask

	// strap change, only while the port is idle
	task automatic set_mode(input logic m);
		@(negedge clock);
		mode = m;
	endtask

	// output enable is asynchronous, so no edge is awaited
	task automatic set_oe(input logic v);
		oe_n = v;
	endtask
endmodule

// ===== dual_port_sram_port_control_test.sv
// self-checking bench: two host models on ports a and b of the ram
// assumes a 100 MHz clock and one access per cycle from each host
`timescale 1ns/1ps
module dual_port_sram_port_control_test;
	import dpsp_pkg::*;

	localparam dpsp_addr_t ADDR_A = 13'h0123;
	localparam dpsp_addr_t ADDR_SHARED = 13'h0abc;
	logic clock;
	logic reset;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	logic a_csl, a_csh, a_ub_n, a_lb_n, a_rw, a_oe_n, a_md, a_ads_n, a_cnt_n, a_clr_n;
	logic b_csl, b_csh, b_ub_n, b_lb_n, b_rw, b_oe_n, b_md, b_ads_n, b_cnt_n, b_clr_n;
	dpsp_addr_t a_addr, b_addr;
	dpsp_word_t a_din, b_din, a_dout, b_dout, exp_w;
	dpsp_lanes_t a_lanes_n, b_lanes_n;

	dpsp_host host_a (.clock(clock), .cs_low(a_csl), .cs_high(a_csh), .ub_n(a_ub_n), .lb_n(a_lb_n),
		.rw(a_rw), .oe_n(a_oe_n), .mode(a_md), .ads_n(a_ads_n), .cnt_n(a_cnt_n), .clr_n(a_clr_n),
		.addr(a_addr), .din(a_din));
	dpsp_host host_b (.clock(clock), .cs_low(b_csl), .cs_high(b_csh), .ub_n(b_ub_n), .lb_n(b_lb_n),
		.rw(b_rw), .oe_n(b_oe_n), .mode(b_md), .ads_n(b_ads_n), .cnt_n(b_cnt_n), .clr_n(b_clr_n),
		.addr(b_addr), .din(b_din));

	dpsp_ram uut (.clock(clock), .reset(reset),
		.port_a_chip_select_low_active(a_csl), .port_a_chip_select_high_active(a_csh),
		.port_a_upper_byte_select_n(a_ub_n), .port_a_lower_byte_select_n(a_lb_n),
		.port_a_read_write(a_rw), .port_a_output_enable_n(a_oe_n), .port_a_output_stage_mode(a_md),
		.port_a_address_load_strobe_n(a_ads_n), .port_a_counter_advance_enable_n(a_cnt_n),
		.port_a_counter_clear_n(a_clr_n), .port_a_address(a_addr), .port_a_data_in(a_din),
		.port_a_data_out(a_dout), .port_a_data_oe_n(a_lanes_n),
		.port_b_chip_select_low_active(b_csl), .port_b_chip_select_high_active(b_csh),
		.port_b_upper_byte_select_n(b_ub_n), .port_b_lower_byte_select_n(b_lb_n),
		.port_b_read_write(b_rw), .port_b_output_enable_n(b_oe_n), .port_b_output_stage_mode(b_md),
		.port_b_address_load_strobe_n(b_ads_n), .port_b_counter_advance_enable_n(b_cnt_n),
		.port_b_counter_clear_n(b_clr_n), .port_b_address(b_addr), .port_b_data_in(b_din),
		.port_b_data_out(b_dout), .port_b_data_oe_n(b_lanes_n));

	initial clock = 1'b0;
	always #5 clock = ~clock;

	// hang guard: the whole run needs well under 200 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// data is compared only on lanes that should be driven
	task automatic chk(input dpsp_word_t got, input dpsp_word_t exp, input dpsp_lanes_t goe, input dpsp_lanes_t eoe);
		dpsp_word_t m;
		m = {{9{!eoe[1]}}, {9{!eoe[0]}}};
		n_checks++;
		if (goe !== eoe || (got & m) !== (exp & m)) begin
			failures++;
			$display("mismatch at %0t: data %h lanes %b, expected %h lanes %b", $time, got, goe, exp, eoe);
		end
	endtask

	// let the rising edge settle before looking
	task automatic tick();
		@(posedge clock);
		#1;
	endtask

	// one read cycle on port a, judged just after its edge
	task automatic rda(input logic sel, input logic [1:0] bs, input logic [2:0] ctl, input dpsp_addr_t ad,
		input dpsp_word_t exp, input dpsp_lanes_t eoe);
		host_a.drive(sel, 1'b1, bs, ctl, ad, WORD_ZERO);
		tick();
		chk(a_dout, exp, a_lanes_n, eoe);
	endtask

	task automatic wrb(input logic [1:0] bs, input logic [2:0] ctl, input dpsp_addr_t ad, input dpsp_word_t d);
		host_b.drive(1'b1, 1'b0, bs, ctl, ad, d);
	endtask

	// lane writes from port b, lane reads on both ports at once
	task automatic t_lanes();
		wrb(2'h0, 3'h3, ADDR_A, 18'h2_aaaa);
		wrb(2'h1, 3'h3, ADDR_A, 18'h1_5555);
		wrb(2'h3, 3'h3, ADDR_A, 18'h3_ffff);
		wrb(2'h2, 3'h7, ADDR_A, 18'h0_4321);
		host_b.idle();
		exp_w = {9'h0aa, 9'h121};
		for (int i = 0; i < 4; i++) begin
			fork
				host_a.drive(1'b1, 1'b1, i[1:0], 3'h3, ADDR_A, WORD_ZERO);
				host_b.drive(1'b1, 1'b1, ~i[1:0], 3'h3, ADDR_A, WORD_ZERO);
			join
			tick();
			chk(a_dout, exp_w, a_lanes_n, i[1:0]);
			chk(b_dout, exp_w, b_lanes_n, ~i[1:0]);
		end
		host_b.idle();
	endtask

	// counter load, wrap, advance, hold, advance while deselected, clear
	task automatic t_counter();
		wrb(2'h0, 3'h3, 13'h1fff, 18'h1_2345);
		wrb(2'h0, 3'h5, ADDR_A, 18'h2_6789);
		wrb(2'h0, 3'h5, ADDR_A, 18'h0_abcd);
		host_b.idle();
		rda(1'b1, 2'h0, 3'h3, 13'h1fff, 18'h1_2345, 2'h0);
		rda(1'b1, 2'h0, 3'h5, ADDR_A, 18'h2_6789, 2'h0);
		rda(1'b1, 2'h0, 3'h7, ADDR_A, 18'h2_6789, 2'h0);
		rda(1'b0, 2'h0, 3'h5, ADDR_A, WORD_ZERO, 2'h3);
		rda(1'b1, 2'h0, 3'h7, ADDR_A, 18'h0_abcd, 2'h0);
		rda(1'b1, 2'h0, 3'h2, 13'h1fff, 18'h2_6789, 2'h0);
		// deselected burst: load then three advances, wrapping to word one
		rda(1'b0, 2'h3, 3'h3, 13'h1ffe, WORD_ZERO, 2'h3);
		repeat (3) begin
			rda(1'b0, 2'h3, 3'h5, ADDR_A, WORD_ZERO, 2'h3);
		end
		rda(1'b1, 2'h0, 3'h7, ADDR_A, 18'h0_abcd, 2'h0);
		host_a.idle();
	endtask

	// pipelined timing: late data, byte selects one stage, selects two
	task automatic t_pipe();
		host_a.set_mode(MODE_PIPE);
		rda(1'b1, 2'h0, 3'h3, ADDR_A, exp_w, 2'h3);
		rda(1'b1, 2'h0, 3'h3, 13'h1fff, exp_w, 2'h0);
		rda(1'b0, 2'h2, 3'h7, ADDR_A, 18'h1_2345, 2'h2);
		rda(1'b0, 2'h0, 3'h7, ADDR_A, exp_w, 2'h3);
		host_a.set_mode(MODE_FLOW);
	endtask

	// output enable floats and restores the lanes between edges
	task automatic t_oe();
		rda(1'b1, 2'h0, 3'h3, ADDR_A, exp_w, 2'h0);
		@(negedge clock);
		host_a.set_oe(1'b1);
		host_b.set_oe(1'b1);
		#1;
		chk(a_dout, exp_w, a_lanes_n, 2'h3);
		@(negedge clock);
		host_a.set_oe(1'b0);
		host_b.set_oe(1'b0);
		#1;
		chk(a_dout, exp_w, a_lanes_n, 2'h0);
		host_a.idle();
		tick();
		chk(a_dout, exp_w, a_lanes_n, 2'h3);
	endtask

	// both ports write one word (port a wins), port a rewrites one lane, both read back
	task automatic t_writes();
		fork
			host_a.drive(1'b1, 1'b0, 2'h0, 3'h3, ADDR_SHARED, 18'h1_1111);
			host_b.drive(1'b1, 1'b0, 2'h0, 3'h3, ADDR_SHARED, 18'h2_2222);
		join
		fork
			host_a.drive(1'b1, 1'b0, 2'h1, 3'h7, ADDR_SHARED, 18'h3_fe00);
			host_b.idle();
		join
		fork
			host_a.drive(1'b1, 1'b1, 2'h0, 3'h3, ADDR_SHARED, WORD_ZERO);
			host_b.drive(1'b1, 1'b1, 2'h0, 3'h3, ADDR_SHARED, WORD_ZERO);
		join
		tick();
		chk(a_dout, 18'h3_ff11, a_lanes_n, 2'h0);
		chk(b_dout, 18'h3_ff11, b_lanes_n, 2'h0);
		fork
			host_a.drive(1'b1, 1'b1, 2'h0, 3'h3, ADDR_A, WORD_ZERO);
			host_b.drive(1'b1, 1'b1, 2'h0, 3'h2, ADDR_SHARED, WORD_ZERO);
		join
		tick();
		chk(a_dout, exp_w, a_lanes_n, 2'h0);
		chk(b_dout, 18'h2_6789, b_lanes_n, 2'h0);
		fork
			host_a.idle();
			host_b.idle();
		join
	endtask

	initial begin
		reset = 1'b1;
		repeat (20) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		#1;
		chk(a_dout, WORD_ZERO, a_lanes_n, LANES_OFF);
		chk(b_dout, WORD_ZERO, b_lanes_n, LANES_OFF);
		t_lanes();
		t_counter();
		t_pipe();
		t_oe();
		t_writes();
		complete_run();
	end
endmodule
